// ---- hw/awtg_pkg.sv ----
// constants for the wake-up tone generator and detector
package awtg_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SYM_BAUD = 120_000;
    // symbol period in clocks, rounded down (833)
    localparam int unsigned SYM_CYCLES = CLK_HZ / SYM_BAUD;
    localparam int unsigned TONE_PERIODS = 16;
    localparam int unsigned HALF_SYMS = 8;
    localparam int unsigned TONE_HZ_X10 = 75;
    localparam int unsigned TONE_US_X1000 = 2133;
    // limits held in units of 10 Hz
    // lower frequency limit: longest interval, rounded down (16260)
    localparam int unsigned F_MIN_HZ_X100 = 615;
    localparam int unsigned MAX_PERIOD_CYC =
        CLK_HZ / (F_MIN_HZ_X100 * 10);
    // upper frequency limit, 8.27 - 8.89 kHz band, nominal 8.58 kHz
    localparam int unsigned F_MAX_HZ_X100 = 858;
    // shortest interval accepted (11656)
    localparam int unsigned MIN_PERIOD_CYC =
        CLK_HZ / (F_MAX_HZ_X100 * 10) + 1;
    localparam int unsigned EDGE_GOAL = 14;
    localparam int unsigned QUIET_US_X100 = 39;
    localparam int unsigned QUIET_CYC =
        (CLK_HZ / 100_000) * QUIET_US_X100;
    localparam int unsigned CNT_W = 20;
    localparam logic [1:0] SYM_ZERO = 2'h0;
    localparam logic [1:0] SYM_PLUS = 2'h1;
    localparam logic [1:0] SYM_MINUS = 2'h2;
endpackage

// ---- hw/awtg_tone_gen.sv ----
// square tone generator: 16 periods of 8 plus and 8 minus symbols
module awtg_tone_gen
    import awtg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic start,
    input wire logic sym_tick,
    // tone output
    output logic active,
    output logic [1:0] tone_sym,
    output logic done
);
    logic [3:0] sym_reg;
    logic [4:0] per_reg;
    logic half_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active <= 1'b0;
            sym_reg <= 4'h0;
            per_reg <= 5'h00;
            half_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!active && start) begin
                active <= 1'b1;
                sym_reg <= 4'h0;
                per_reg <= 5'h00;
                half_reg <= 1'b0;
            end else if (active && sym_tick) begin
                if (sym_reg == 4'(HALF_SYMS - 1)) begin
                    sym_reg <= 4'h0;
                    half_reg <= ~half_reg;
                    if (half_reg) begin
                        if (per_reg == 5'(TONE_PERIODS - 1)) begin
                            active <= 1'b0;
                            done <= 1'b1;
                        end
                        per_reg <= per_reg + 5'h01;
                    end
                end else begin
                    sym_reg <= sym_reg + 4'h1;
                end
            end
        end
    end

    always_comb begin
        if (!active) tone_sym = SYM_ZERO;
        else if (half_reg) tone_sym = SYM_MINUS;
        else tone_sym = SYM_PLUS;
    end

    tone_len_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(active) |-> active [*8])
        else $error("tone stopped too early");
endmodule

// ---- hw/awtg_top.sv ----
// wake-up / acknowledge tone generator and detector for a line port
module awtg_top
    import awtg_pkg::*;
#(
    parameter int unsigned SYM_DIV = SYM_CYCLES,
    parameter int unsigned MIN_PER = MIN_PERIOD_CYC,
    parameter int unsigned MAX_PER = MAX_PERIOD_CYC,
    parameter int unsigned QUIET = QUIET_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // activation control
    input wire logic wake_req,
    input wire logic ack_enable,
    output logic wake_detected,
    output logic tone_done,
    output logic tone_busy,
    // normal transmit path
    input wire logic [1:0] payload_sym,
    input wire logic frame_sync,
    // line side
    input wire logic line_in,
    output logic [1:0] line_sym,
    output logic sym_strobe,
    output logic frame_sync_out
);
    logic [9:0] div_reg;
    logic sync1_reg, sync2_reg, prev_reg;
    logic [CNT_W-1:0] rise_cnt_reg, fall_cnt_reg;
    logic [3:0] edges_reg;
    logic armed_reg, ack_pend_reg, gen_start;
    logic [1:0] tone_sym;
    logic rise, fall;

    // shared symbol timing for tone and ordinary traffic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 10'h000;
            sym_strobe <= 1'b0;
        end else begin
            sym_strobe <= (div_reg == 10'(SYM_DIV - 1));
            if (div_reg == 10'(SYM_DIV - 1)) div_reg <= 10'h000;
            else div_reg <= div_reg + 10'h001;
        end
    end

    // start on local request or as acknowledge of far-end tone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ack_pend_reg <= 1'b0;
        else if (wake_detected && ack_enable) ack_pend_reg <= 1'b1;
        else if (tone_busy) ack_pend_reg <= 1'b0;
    end
    assign gen_start = wake_req || ack_pend_reg;

    awtg_tone_gen u_gen (
        .clk(clk),
        .arst_n(arst_n),
        .start(gen_start),
        .sym_tick(sym_strobe),
        .active(tone_busy),
        .tone_sym(tone_sym),
        .done(tone_done)
    );

    // line mux: tone replaces coded data and frame word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_sym <= SYM_ZERO;
            frame_sync_out <= 1'b0;
        end else if (tone_busy) begin
            line_sym <= tone_sym;
            frame_sync_out <= 1'b0;
        end else begin
            line_sym <= payload_sym;
            frame_sync_out <= frame_sync;
        end
    end

    // line input synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= line_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign rise = sync2_reg && !prev_reg;
    assign fall = !sync2_reg && prev_reg;

    function automatic logic in_band(input logic [CNT_W-1:0] c);
        in_band = (c >= CNT_W'(MIN_PER)) &&
                  (c <= CNT_W'(MAX_PER));
    endfunction

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
        bump = (&c) ? c : c + CNT_W'(1);
    endfunction

    // rising interval measurement and consecutive edge count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_cnt_reg <= '1;
            edges_reg <= 4'h0;
        end else if (rise) begin
            rise_cnt_reg <= CNT_W'(1);
            if (armed_reg) edges_reg <= 4'h0;
            else if (in_band(rise_cnt_reg))
                edges_reg <= edges_reg + 4'h1;
            else edges_reg <= 4'h0;
        end else begin
            rise_cnt_reg <= bump(rise_cnt_reg);
            if (armed_reg) edges_reg <= 4'h0;
        end
    end

    // falling-edge quiet timer after the edge goal is reached
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt_reg <= '1;
            armed_reg <= 1'b0;
            wake_detected <= 1'b0;
        end else begin
            wake_detected <= 1'b0;
            if (fall) fall_cnt_reg <= CNT_W'(1);
            else fall_cnt_reg <= bump(fall_cnt_reg);
            if (!armed_reg && rise && in_band(rise_cnt_reg) &&
                edges_reg == 4'(EDGE_GOAL - 1)) begin
                armed_reg <= 1'b1;
            end else if (armed_reg &&
                         fall_cnt_reg >= CNT_W'(QUIET) && !fall) begin
                armed_reg <= 1'b0;
                wake_detected <= 1'b1;
            end
        end
    end

    no_frame_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $past(tone_busy) |-> !frame_sync_out)
        else $error("frame word during tone");
    tone_sym_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $past(tone_busy) |-> line_sym != SYM_ZERO)
        else $error("zero symbol inside tone");
    strobe_gap_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sym_strobe |=> !sym_strobe [*8])
        else $error("symbol strobe too fast");
    wake_quiet_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wake_detected |-> $past(armed_reg) &&
            $past(fall_cnt_reg) >= CNT_W'(QUIET))
        else $error("wake reported without quiet window");
    ack_start_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wake_detected && ack_enable && !tone_busy |-> ##[1:3] tone_busy)
        else $error("no acknowledge tone");
    req_start_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wake_req && !tone_busy |=> tone_busy)
        else $error("wake request ignored");
    bad_edge_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        rise && !in_band(rise_cnt_reg) && !armed_reg |=> edges_reg == 4'h0)
        else $error("out of band edge kept count");
    arm_goal_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(armed_reg) |-> $past(edges_reg) == 4'(EDGE_GOAL - 1))
        else $error("armed before edge goal");

    tone_c: cover property (@(posedge clk) $fell(tone_busy));
    wake_c: cover property (@(posedge clk) wake_detected);
    arm_c: cover property (@(posedge clk) $rose(armed_reg));
endmodule

// ---- testbench/awtg_peer.sv ----
// far-end line transceiver: sends a square tone on the sliced line
module awtg_peer (
    // clock
    input wire logic clk,
    // line side
    output logic line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // silent line slices to low
    initial line_in = 1'b0;
    // n periods, each half cycles high then half low
    task automatic tone(input int half, input int n);
        repeat (n) begin
            @(posedge clk);
            line_in <= 1'b1;
            repeat (half) @(posedge clk);
            line_in <= 1'b0;
            repeat (half - 1) @(posedge clk);
        end
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the wake-up tone generator and detector
module tb_top;
    import awtg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // symbol and detector timing scaled down to keep the run short
    localparam int DIV = 10;
    localparam int SCALE = 10;
    localparam int MINP = MIN_PERIOD_CYC / SCALE;
    localparam int MAXP = MAX_PERIOD_CYC / SCALE;
    localparam int QUIET_T = QUIET_CYC / SCALE;
    localparam int HALF = 667;
    logic clk = 0, arst_n = 0, wake_req = 0, ack_enable = 0;
    logic frame_sync = 0, line_in;
    logic [1:0] payload_sym = SYM_ZERO, line_sym;
    logic wake_detected, tone_done, tone_busy, sym_strobe, frame_sync_out;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #5 clk = ~clk;
    awtg_peer awtg_peer_inst (.clk(clk), .line_in(line_in));
    awtg_top #(.SYM_DIV(DIV), .MIN_PER(MINP), .MAX_PER(MAXP),
        .QUIET(QUIET_T)) awtg_top_inst (
        .clk(clk), .arst_n(arst_n), .wake_req(wake_req),
        .ack_enable(ack_enable), .wake_detected(wake_detected),
        .tone_done(tone_done), .tone_busy(tone_busy),
        .payload_sym(payload_sym), .frame_sync(frame_sync),
        .line_in(line_in), .line_sym(line_sym),
        .sym_strobe(sym_strobe), .frame_sync_out(frame_sync_out));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // watches one whole tone from its start
    task automatic tone_watch();
        int pl = 0, mi = 0, fl = 0, st = 0, gap = 0, bg = 0, bad = 0, k = 0;
        logic dn = 0;
        logic [1:0] pv = SYM_ZERO;
        while (tone_busy !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        check("tone_busy", 1, tone_busy);
        k = 0;
        while ((tone_busy === 1'b1 || line_sym !== SYM_ZERO) && k < 9000) begin
            pl += (line_sym === SYM_PLUS);
            mi += (line_sym === SYM_MINUS);
            fl += (pv === SYM_PLUS && line_sym === SYM_MINUS);
            bad += (line_sym !== SYM_ZERO && frame_sync_out !== 1'b0);
            dn |= (tone_done === 1'b1);
            gap++;
            if (sym_strobe === 1'b1 && tone_busy === 1'b1) begin
                st++;
                bg += (st > 1 && gap != DIV);
                gap = 0;
            end
            pv = line_sym;
            k++;
            @(negedge clk);
        end
        check("plus time", 1, pl > 127 * DIV && pl <= 128 * DIV + 1);
        check("minus time", 1, mi > 127 * DIV && mi <= 128 * DIV + 1);
        check("periods", 16, fl);
        check("ticks", 256, st);
        check("tick gaps", 0, bg);
        check("sync in tone", 0, bad);
        check("tone_done", 1, dn);
    endtask
    task automatic t_wake();
        @(posedge clk);
        frame_sync <= 1'b1;
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        tone_watch();
        @(posedge clk);
        payload_sym <= SYM_PLUS;
        repeat (2) @(negedge clk);
        check("frame_sync_out", 1, frame_sync_out);
        check("line_sym", SYM_PLUS, line_sym);
        @(posedge clk);
        payload_sym <= SYM_ZERO;
        frame_sync <= 1'b0;
        $display("test wake done");
    endtask
    task automatic t_ack();
        int k = 0;
        int qk = QUIET_T - HALF;
        @(posedge clk);
        ack_enable <= 1'b1;
        awtg_peer_inst.tone(HALF, 16);
        while (wake_detected !== 1'b1 && k < QUIET_T) begin
            @(negedge clk);
            k++;
        end
        check("wake_detected", 1, wake_detected);
        check("quiet wait", 1, k > qk - 5 && k < qk + 12);
        tone_watch();
        @(posedge clk);
        ack_enable <= 1'b0;
        $display("test ack done");
    endtask
    task automatic t_band();
        int seen = 0;
        // one tone just above the upper limit, one just below the lower
        awtg_peer_inst.tone(MINP / 2 - 50, 16);
        awtg_peer_inst.tone(MAXP / 2 + 50, 16);
        repeat (QUIET_T + 600) begin
            @(negedge clk);
            seen += (wake_detected !== 1'b0);
        end
        check("off band tones", 0, seen);
        $display("test band done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_wake();
        t_band();
        t_ack();
        report_and_stop();
    end
endmodule
